// >>> hw/fpk_pkg.sv
package fpk_pkg;
  // register byte offsets from the block base
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_PPROT = 8'h14;
  localparam logic [7:0] OFS_VPROT = 8'h18;
  // field positions
  localparam int STS_PASS = 0;
  localparam int STS_FAIL = 1;
  localparam int STS_BUSY = 2;
  localparam int MOD_WEN = 3;
  localparam int MOD_KEY_LOW = 5;
  localparam int MOD_KEY_EN = 6;
  localparam int READ_GUARD = 31;
  // command codes
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_ERWR = 8'h03;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_PERASE = 8'h05;
  localparam logic [7:0] CMD_MASS = 8'h06;
  localparam logic [7:0] CMD_SAVE = 8'h0c;
  // values after reset or erase, and the permanent key
  localparam logic [7:0] CMD_RST = 8'h07;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [31:0] PROT_OPEN = 32'hffffffff;
  localparam logic [31:0] PROT_ALL = 32'h00000000;
  localparam logic [31:0] KEY_ERASED = 32'hffffffff;
  localparam logic [31:0] KEY_PERMANENT = 32'hdeaddead;
  localparam logic [15:0] CELL_ERASED = 16'hffff;
  // geometry in half words, one bit of protection per 2 kB group
  localparam int ARRAY_KB = 64;
  localparam int USER_KB = 62;
  localparam int HW_WORDS = ARRAY_KB * 512;
  localparam int USER_WORDS = USER_KB * 512;
  localparam int PAGE_WORDS = 256;
  localparam logic [4:0] HIDDEN_GROUP = 5'h1f;
  // timing at 50 ns per cycle
  localparam int CLK_NS = 50;
  localparam int WRITE_NS = 50000;
  localparam int WRITE_CYC = (WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERWR_MS = 24;
  localparam int ERWR_CYC = ERWR_MS * 1000000 / CLK_NS;
  localparam int MASS_MS = 2480;
  localparam longint MASS_CYC = longint'(MASS_MS) * 1000000 / CLK_NS;
  localparam int PERASE_MS = 20;
  localparam int PERASE_CYC = PERASE_MS * 1000000 / CLK_NS;
  localparam logic [1:0] BOOT_SETTLE = 2'h3;
  typedef enum logic [1:0] {FPK_IDLE, FPK_SWEEP, FPK_WAIT, FPK_FINISH}
    fpk_state_t;
endpackage

// >>> hw/fpk_top.sv
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - array is 64 kB; lower 62 kB user, upper 2 kB firmware.
// - firmware 2 kB cannot be read or changed by user accesses.
// - cells are erased before programming; erase only whole pages.
// - boot pin low at reset release selects serial download mode.
// - user space loadable by serial firmware path or JTAG path.
// - cleared protection bit 31 blocks JTAG reads of user space.
// - other 31 bits each guard four pages, 2 kB, against write/erase.
// - write protection applies on processor, serial and JTAG paths.
// - volatile protection writable any time, lost on reset.
// - persistent protection acts only after save command 0x0C and reset.
// - key stored once; later saves need the matching key.
// - mass erase restores the erased key and wipes user code.
// - key 0xDEADDEAD makes protection permanent; key entry refused.
// - with that key only mass erase clears protection.
// - key is address half then data half, 16 bits each.
// - protection bits are active low; zero protects its group.
// - status bit0 pass, bit1 fail, bit2 busy; pass/fail clear on read.
// - mode bit 3 set enables write and erase commands.
// - mass erase 0x06 clears 62 kB user space, firmware kept.
module fpk_top #(
  parameter int unsigned ERWR_CYC = fpk_pkg::ERWR_CYC,
  parameter int unsigned MASS_CYC = 32'(fpk_pkg::MASS_CYC),
  parameter int unsigned PERASE_CYC = fpk_pkg::PERASE_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pwr_on_rst,
  input wire logic boot_mode_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic download_mode,
  input wire logic ext_req,
  input wire logic ext_wr,
  input wire logic ext_jtag,
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_wdata,
  output logic [15:0] ext_rdata,
  output logic ext_ok,
  output logic ext_err,
  output logic [31:0] active_prot
);
  if (ERWR_CYC < 1 || MASS_CYC < 1 || PERASE_CYC < 1) begin : g_chk
    $error("fpk_top: cycle counts must be at least one");
  end

  fpk_pkg::fpk_state_t st_q;
  logic boot_s1_q, boot_s2_q, latched_q, download_q;
  logic [1:0] settle_q;
  logic [31:0] applied_q, vol_q, pend_q, nv_prot_q, nv_key_q, key_hold_q;
  logic [15:0] mode_q, data_q, addr_q, ext_rdata_q;
  logic [7:0] cmd_q, op_q;
  logic [14:0] sweep_q, sweep_end_q;
  logic [31:0] timer_q, rdata_q;
  logic pass_q, fail_q, ext_ok_q, ext_err_q;
  // the whole array in half words, firmware group included
  logic [15:0] mem [fpk_pkg::HW_WORDS];

  // a zero in either register protects the group
  logic [31:0] eff_prot;
  assign eff_prot = applied_q & vol_q;

  // boot pin crosses in from the board
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_s1_q <= 1'b1;
      boot_s2_q <= 1'b1;
    end else begin
      boot_s1_q <= boot_mode_pin;
      boot_s2_q <= boot_s1_q;
    end
  end

  // wait until the synchroniser holds the real pin level
  logic capture;
  assign capture = !latched_q && settle_q == fpk_pkg::BOOT_SETTLE;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_q <= 2'h0;
      latched_q <= 1'b0;
    end else if (capture) begin
      latched_q <= 1'b1;
    end else if (!latched_q) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // mode and saved protection are caught once after release
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      download_q <= 1'b0;
      applied_q <= fpk_pkg::PROT_ALL; // safe until loaded
    end else if (capture) begin
      download_q <= !boot_s2_q;
      applied_q <= nv_prot_q;
    end
  end
  // outputs straight from state; active_prot is the live mask
  assign download_mode = download_q;
  assign active_prot = eff_prot;

  // register strobes
  logic wr_mode, wr_cmd, wr_data, wr_addr, wr_pprot, wr_vprot, rd_sts;
  assign wr_mode = reg_wr && reg_addr == fpk_pkg::OFS_MODE;
  assign wr_cmd = reg_wr && reg_addr == fpk_pkg::OFS_CMD;
  assign wr_data = reg_wr && reg_addr == fpk_pkg::OFS_DATA;
  assign wr_addr = reg_wr && reg_addr == fpk_pkg::OFS_ADDR;
  assign wr_pprot = reg_wr && reg_addr == fpk_pkg::OFS_PPROT;
  assign wr_vprot = reg_wr && reg_addr == fpk_pkg::OFS_VPROT;
  assign rd_sts = reg_rd && reg_addr == fpk_pkg::OFS_STATUS;

  // target of the current command
  logic [14:0] word;
  logic [4:0] grp;
  logic hidden, grp_open, wen, keyed, key_match, go, go_ok;
  logic [7:0] code;
  assign word = addr_q[15:1];
  assign grp = addr_q[15:11];
  assign hidden = grp == fpk_pkg::HIDDEN_GROUP;
  assign grp_open = eff_prot[grp];
  assign wen = mode_q[fpk_pkg::MOD_WEN];
  assign keyed = nv_key_q != fpk_pkg::KEY_ERASED;
  assign key_match = {addr_q, data_q} == nv_key_q;
  assign code = reg_wdata[7:0];
  // commands written while busy are dropped
  assign go = wr_cmd && st_q == fpk_pkg::FPK_IDLE &&
    code != fpk_pkg::CMD_NULL;

  // admission check, taken at the command write
  always_comb begin
    go_ok = 1'b0;
    unique case (code)
      fpk_pkg::CMD_READ, fpk_pkg::CMD_VERIFY: go_ok = !hidden;
      fpk_pkg::CMD_WRITE, fpk_pkg::CMD_ERWR, fpk_pkg::CMD_PERASE:
        go_ok = wen && !hidden && grp_open;
      fpk_pkg::CMD_MASS: go_ok = wen;
      fpk_pkg::CMD_SAVE:
        go_ok = mode_q[fpk_pkg::MOD_KEY_EN] &&
          !mode_q[fpk_pkg::MOD_KEY_LOW] &&
          (!keyed || (key_match &&
          nv_key_q != fpk_pkg::KEY_PERMANENT));
      default: go_ok = 1'b0;
    endcase
  end

  // plain software registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= fpk_pkg::MODE_RST;
      addr_q <= 16'h0000;
      pend_q <= fpk_pkg::PROT_OPEN;
      vol_q <= fpk_pkg::PROT_OPEN;
    end else begin
      if (wr_mode) mode_q <= reg_wdata[15:0];
      if (wr_addr && st_q == fpk_pkg::FPK_IDLE) addr_q <= reg_wdata[15:0];
      if (wr_pprot) pend_q <= reg_wdata; // staged only
      if (wr_vprot) vol_q <= reg_wdata;
    end
  end

  // command register holds the last nonzero code written while idle, refused codes included
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) cmd_q <= fpk_pkg::CMD_RST;
    else if (go) cmd_q <= code;
  end

  // data register, also loaded by a read command
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      data_q <= 16'h0000;
    end else if (st_q == fpk_pkg::FPK_FINISH &&
                 op_q == fpk_pkg::CMD_READ) begin
      data_q <= mem[word];
    end else if (wr_data && st_q == fpk_pkg::FPK_IDLE) begin
      data_q <= reg_wdata[15:0];
    end
  end

  // sequencer: sweep erases one half word a cycle, then the cell time
  logic sweep_done, fin_pass, fin_fail;
  assign sweep_done = sweep_q == sweep_end_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= fpk_pkg::FPK_IDLE;
      op_q <= fpk_pkg::CMD_NULL;
      sweep_q <= 15'h0000;
      sweep_end_q <= 15'h0000;
      timer_q <= 32'h00000000;
      key_hold_q <= 32'h00000000;
    end else begin
      // erase types sweep first; write, save and read skip the sweep
      unique case (st_q)
        fpk_pkg::FPK_IDLE: if (go && go_ok) begin
          op_q <= code;
          key_hold_q <= {addr_q, data_q};
          sweep_q <= {word[14:8], 8'h00};
          sweep_end_q <= {word[14:8], 8'hff};
          timer_q <= 32'(fpk_pkg::WRITE_CYC);
          unique case (code)
            fpk_pkg::CMD_READ, fpk_pkg::CMD_VERIFY:
              st_q <= fpk_pkg::FPK_FINISH;
            fpk_pkg::CMD_WRITE, fpk_pkg::CMD_SAVE:
              st_q <= fpk_pkg::FPK_WAIT;
            fpk_pkg::CMD_MASS: begin
              sweep_q <= 15'h0000;
              sweep_end_q <= 15'(fpk_pkg::USER_WORDS - 1);
              st_q <= fpk_pkg::FPK_SWEEP;
            end
            default: st_q <= fpk_pkg::FPK_SWEEP;
          endcase
        end
        fpk_pkg::FPK_SWEEP: begin
          sweep_q <= sweep_q + 15'h0001;
          if (sweep_done) begin
            st_q <= fpk_pkg::FPK_WAIT;
            if (op_q == fpk_pkg::CMD_MASS) timer_q <= MASS_CYC;
            else if (op_q == fpk_pkg::CMD_ERWR) timer_q <= ERWR_CYC;
            else timer_q <= PERASE_CYC;
          end
        end
        fpk_pkg::FPK_WAIT: begin
          timer_q <= timer_q - 32'h00000001;
          if (timer_q <= 32'h00000001) st_q <= fpk_pkg::FPK_FINISH;
        end
        fpk_pkg::FPK_FINISH: st_q <= fpk_pkg::FPK_IDLE;
      endcase
    end
  end

  // verify reports a mismatch as a failed command
  logic vfy_bad;
  assign vfy_bad = op_q == fpk_pkg::CMD_VERIFY && mem[word] != data_q;
  assign fin_pass = st_q == fpk_pkg::FPK_FINISH && !vfy_bad;
  assign fin_fail = st_q == fpk_pkg::FPK_FINISH && vfy_bad;

  // side path for serial download firmware and jtag, idle only
  logic [14:0] ext_word;
  logic [4:0] ext_grp;
  logic ext_take, ext_bad;
  assign ext_word = ext_addr[15:1];
  assign ext_grp = ext_addr[15:11];
  assign ext_take = ext_req && st_q == fpk_pkg::FPK_IDLE;
  always_comb begin
    ext_bad = ext_grp == fpk_pkg::HIDDEN_GROUP;
    if (ext_wr && !eff_prot[ext_grp]) ext_bad = 1'b1;
    if (!ext_wr && ext_jtag && !eff_prot[fpk_pkg::READ_GUARD])
      ext_bad = 1'b1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_ok_q <= 1'b0;
      ext_err_q <= 1'b0;
      ext_rdata_q <= 16'h0000;
    end else begin
      ext_ok_q <= ext_take && !ext_bad;
      ext_err_q <= ext_req && (ext_bad || !ext_take);
      if (ext_take && !ext_bad && !ext_wr) ext_rdata_q <= mem[ext_word];
    end
  end
  // answers are registered, one cycle after the request
  assign ext_ok = ext_ok_q;
  assign ext_err = ext_err_q;
  assign ext_rdata = ext_rdata_q;

  // array: programming can only clear bits, so erase must come first
  always_ff @(posedge mclk) begin
    if (st_q == fpk_pkg::FPK_SWEEP) begin
      mem[sweep_q] <= fpk_pkg::CELL_ERASED;
    end else if (st_q == fpk_pkg::FPK_FINISH &&
                 (op_q == fpk_pkg::CMD_WRITE ||
                  op_q == fpk_pkg::CMD_ERWR)) begin
      mem[word] <= mem[word] & data_q;
    end else if (ext_take && !ext_bad && ext_wr) begin
      mem[ext_word] <= mem[ext_word] & ext_wdata;
    end
  end

  // persistent state survives the system reset, only power-on or a mass erase clears it
  // a save lands at finish; the applied copy waits for the next reset
  always_ff @(posedge mclk or posedge pwr_on_rst) begin
    if (pwr_on_rst) begin
      nv_prot_q <= fpk_pkg::PROT_OPEN;
      nv_key_q <= fpk_pkg::KEY_ERASED;
    end else if (st_q == fpk_pkg::FPK_FINISH) begin
      if (op_q == fpk_pkg::CMD_SAVE) begin
        nv_prot_q <= pend_q;
        nv_key_q <= key_hold_q;
      end else if (op_q == fpk_pkg::CMD_MASS) begin
        nv_prot_q <= fpk_pkg::PROT_OPEN;
        nv_key_q <= fpk_pkg::KEY_ERASED;
      end
    end
  end

  // a command refused at its write counts as a failed result
  logic refuse;
  assign refuse = go && !go_ok;

  // sticky status, a new result beats the clearing read and
  // replaces the other flag, so pass and fail never show together
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      if (fin_pass) pass_q <= 1'b1;
      else if (rd_sts || fin_fail || refuse) pass_q <= 1'b0;
      if (fin_fail || refuse) fail_q <= 1'b1;
      else if (rd_sts || fin_pass) fail_q <= 1'b0;
    end
  end

  // registered read data, unmapped offsets read zero
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        fpk_pkg::OFS_STATUS: rdata_q <= {29'h0,
          st_q != fpk_pkg::FPK_IDLE, fail_q, pass_q};
        fpk_pkg::OFS_MODE: rdata_q <= {16'h0000, mode_q};
        fpk_pkg::OFS_CMD: rdata_q <= {24'h000000, cmd_q};
        fpk_pkg::OFS_DATA: rdata_q <= {16'h0000, data_q};
        fpk_pkg::OFS_ADDR: rdata_q <= {16'h0000, addr_q};
        fpk_pkg::OFS_PPROT: rdata_q <= pend_q;
        fpk_pkg::OFS_VPROT: rdata_q <= vol_q;
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end
  assign reg_rdata = rdata_q;
endmodule

// >>> tb/fpk_asserts.sv
`timescale 1ns/1ps
module fpk_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic ext_req,
  input wire logic ext_wr,
  input wire logic ext_jtag,
  input wire logic [15:0] ext_addr,
  input wire logic ext_ok,
  input wire logic ext_err,
  input wire logic [31:0] active_prot
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // every side access gets exactly one answer, next cycle
  property p_ext_resp;
    ext_req |=> ext_ok != ext_err;
  endproperty
  a_ext_resp: assert property (p_ext_resp) else $error("no ext answer");
  property p_ext_quiet;
    !ext_req |=> !ext_ok && !ext_err;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("stray answer");
  property p_hidden;
    ext_req && ext_addr[15:11] == fpk_pkg::HIDDEN_GROUP |=> ext_err;
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden reached");
  property p_jtag_guard;
    ext_req && ext_jtag && !ext_wr && !active_prot[31] |=> ext_err;
  endproperty
  a_jtag_guard: assert property (p_jtag_guard) else $error("jtag read");
  property p_wr_guard;
    ext_req && ext_wr && !active_prot[ext_addr[15:11]] |=> ext_err;
  endproperty
  a_wr_guard: assert property (p_wr_guard) else $error("prot write");
  // a cleared volatile bit must show at once in the effective mask
  property p_vprot;
    reg_wr && reg_addr == fpk_pkg::OFS_VPROT
      |=> (active_prot & ~$past(reg_wdata)) == 32'h00000000;
  endproperty
  a_vprot: assert property (p_vprot) else $error("vprot not applied");
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_sts_bits;
    reg_rd && reg_addr == fpk_pkg::OFS_STATUS
      |=> reg_rdata[31:3] == 29'h0 && !(reg_rdata[0] && reg_rdata[1]);
  endproperty
  a_sts_bits: assert property (p_sts_bits) else $error("bad status");
endmodule
bind fpk_top fpk_asserts fpk_asserts_i (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .reg_rd(reg_rd),
  .reg_wr(reg_wr),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .ext_req(ext_req),
  .ext_wr(ext_wr),
  .ext_jtag(ext_jtag),
  .ext_addr(ext_addr),
  .ext_ok(ext_ok),
  .ext_err(ext_err),
  .active_prot(active_prot)
);

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] ST = fpk_pkg::OFS_STATUS;
  localparam logic [7:0] MD = fpk_pkg::OFS_MODE;
  localparam logic [7:0] CM = fpk_pkg::OFS_CMD;
  localparam logic [7:0] DT = fpk_pkg::OFS_DATA;
  localparam logic [7:0] AD = fpk_pkg::OFS_ADDR;
  localparam logic [7:0] PP = fpk_pkg::OFS_PPROT;
  localparam logic [7:0] VP = fpk_pkg::OFS_VPROT;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic pwr_on_rst = 1'b1;
  logic boot_mode_pin = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_req = 1'b0;
  logic ext_wr = 1'b0;
  logic ext_jtag = 1'b0;
  logic [15:0] ext_addr = 16'h0;
  logic [15:0] ext_wdata = 16'h0;
  logic [31:0] reg_rdata;
  logic [31:0] active_prot;
  logic [15:0] ext_rdata;
  logic download_mode;
  logic ext_ok;
  logic ext_err;
  logic [31:0] v;
  // write data for the next side-path program
  logic [15:0] ext_wd = 16'h0;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  // 50 ns clock
  always #25 mclk = ~mclk;
  // short erase waits keep the run within budget
  fpk_top #(.ERWR_CYC(4), .MASS_CYC(4), .PERASE_CYC(4)) fpk_top_i (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pwr_on_rst(pwr_on_rst),
    .boot_mode_pin(boot_mode_pin),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .download_mode(download_mode),
    .ext_req(ext_req),
    .ext_wr(ext_wr),
    .ext_jtag(ext_jtag),
    .ext_addr(ext_addr),
    .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata),
    .ext_ok(ext_ok),
    .ext_err(ext_err),
    .active_prot(active_prot)
  );
  task tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // polls until pass or fail shows; the read clears it
  task cmd(input logic [7:0] c, output logic [31:0] s);
    wr(CM, {24'h0, c});
    s = 32'h0;
    for (int i = 0; i < 40000 && s[1:0] == 2'b00; i++)
      rd(ST, s);
  endtask
  task ext(input logic w, input logic j, input logic [15:0] a,
           input logic ok, input string n);
    @(posedge mclk);
    ext_req <= 1'b1;
    ext_wr <= w;
    ext_jtag <= j;
    ext_addr <= a;
    ext_wdata <= ext_wd;
    @(posedge mclk);
    ext_req <= 1'b0;
    #1 chk(n, {30'h0, ext_ok, ext_err}, {30'h0, ok, !ok});
  endtask
  // six edges covers the boot and protection settle count
  task rst(input logic por);
    @(posedge mclk);
    sys_rst <= 1'b1;
    pwr_on_rst <= por;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    pwr_on_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task save(input logic [31:0] p, input logic [31:0] k);
    wr(PP, p);
    wr(MD, 32'h48);
    wr(AD, {16'h0, k[31:16]});
    wr(DT, {16'h0, k[15:0]});
    cmd(fpk_pkg::CMD_SAVE, v);
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 95000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst(1'b1);
    chk("download_mode", {31'h0, download_mode}, 32'h1);
    chk("prot_open", active_prot, 32'hffffffff);
    rd(ST, v);
    chk("status_idle", v, 32'h0);
    rd(8'h1c, v);
    chk("unmapped", v, 32'h0);
    wr(MD, 32'h0);
    wr(AD, 32'h0);
    cmd(fpk_pkg::CMD_WRITE, v);
    chk("write_locked", v, 32'h2);
    wr(VP, 32'hfffffffd);
    chk("vprot", active_prot, 32'hfffffffd);
    ext(1'b1, 1'b0, 16'h0800, 1'b0, "ser_wr_grp1");
    ext(1'b1, 1'b1, 16'h0800, 1'b0, "jtag_wr_grp1");
    ext(1'b0, 1'b0, 16'hf800, 1'b0, "hidden_rd");
    wr(MD, 32'h8);
    wr(AD, 32'h0800);
    cmd(fpk_pkg::CMD_PERASE, v);
    chk("erase_prot", v, 32'h2);
    wr(AD, 32'h0);
    cmd(fpk_pkg::CMD_PERASE, v);
    chk("erase_pg0", v, 32'h1);
    wr(DT, 32'h1234);
    cmd(fpk_pkg::CMD_WRITE, v);
    chk("prog1", v, 32'h1);
    wr(DT, 32'hff0f);
    wr(CM, {24'h0, fpk_pkg::CMD_WRITE});
    rd(ST, v);
    chk("busy", v, 32'h4);
    cmd(fpk_pkg::CMD_WRITE, v);
    chk("prog2", v, 32'h1);
    cmd(fpk_pkg::CMD_READ, v);
    chk("read_cmd", v, 32'h1);
    rd(DT, v);
    chk("read_data", v, 32'h1204);
    wr(DT, 32'h1204);
    cmd(fpk_pkg::CMD_VERIFY, v);
    chk("verify_ok", v, 32'h1);
    wr(DT, 32'h1205);
    cmd(fpk_pkg::CMD_VERIFY, v);
    chk("verify_bad", v, 32'h2);
    ext(1'b0, 1'b1, 16'h0000, 1'b1, "jtag_rd");
    chk("anded", {16'h0, ext_rdata}, 32'h1204);
    wr(DT, 32'h00ff);
    cmd(fpk_pkg::CMD_ERWR, v);
    chk("erwr_sts", v, 32'h1);
    ext(1'b0, 1'b1, 16'h0000, 1'b1, "jtag_rd2");
    chk("erwr", {16'h0, ext_rdata}, 32'h00ff);
    wr(VP, 32'h7fffffff);
    ext(1'b0, 1'b1, 16'h0000, 1'b0, "jtag_guard");
    ext(1'b0, 1'b0, 16'h0000, 1'b1, "ser_rd");
    save(32'hfffffffd, 32'h12345678);
    chk("save", v, 32'h1);
    chk("no_early", active_prot, 32'h7fffffff);
    rst(1'b0);
    chk("applied", active_prot, 32'hfffffffd);
    ext(1'b1, 1'b0, 16'h0800, 1'b0, "pers_guard");
    save(32'hffffffff, 32'h11115678);
    chk("bad_key", v, 32'h2);
    save(32'hffffffff, 32'h12345678);
    chk("good_key", v, 32'h1);
    rst(1'b0);
    chk("removed", active_prot, 32'hffffffff);
    wr(MD, 32'h8);
    cmd(fpk_pkg::CMD_MASS, v);
    chk("mass1", v, 32'h1);
    rst(1'b0);
    save(32'hfffffffe, 32'hdeaddead);
    chk("key_freed", v, 32'h1);
    rst(1'b0);
    chk("dead_prot", active_prot, 32'hfffffffe);
    save(32'hffffffff, 32'hdeaddead);
    chk("dead_locked", v, 32'h2);
    wr(MD, 32'h8);
    cmd(fpk_pkg::CMD_MASS, v);
    chk("mass2", v, 32'h1);
    rst(1'b0);
    chk("unprotected", active_prot, 32'hffffffff);
    ext(1'b0, 1'b0, 16'h0000, 1'b1, "erased_rd");
    chk("erased", {16'h0, ext_rdata}, 32'hffff);
    ext_wd = 16'h5a5a;
    ext(1'b1, 1'b0, 16'h0000, 1'b1, "ext_prog");
    ext(1'b0, 1'b0, 16'h0000, 1'b1, "ext_back");
    chk("ext_data", {16'h0, ext_rdata}, 32'h5a5a);
    boot_mode_pin <= 1'b1;
    rst(1'b0);
    chk("user_boot", {31'h0, download_mode}, 32'h0);
    tally_and_finish();
  end
endmodule
